// *** bench/three_phase_reset_sync_pwm_tb.sv ***
// Self-checking bench for the three-phase reset-synchronized PWM block
`timescale 1ns/100ps
module three_phase_reset_sync_pwm_tb
  import rspwm_pkg::*;
();
  ////////////////////////////////////////////////////////////////////////
  // One counter clock is 160 ns, 16 cycles at 100 MHz
  localparam int TICK = 16;
  localparam int PER = 9;
  localparam int LIMIT = 20000;

  // Clock, reset and bus drives
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic period_toggle_out, phase1_pos_out, phase1_neg_out;
  logic phase2_pos_out, phase2_neg_out, phase3_pos_out, phase3_neg_out;
  logic irq;
  logic [7:0] pins;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  // Observed pins by index
  assign pins = {irq, phase3_neg_out, phase3_pos_out, phase2_neg_out,
                 phase2_pos_out, phase1_neg_out, phase1_pos_out,
                 period_toggle_out};

  three_phase_reset_sync_pwm u_dut (
    .aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .period_toggle_out, .phase1_pos_out, .phase1_neg_out,
    .phase2_pos_out, .phase2_neg_out, .phase3_pos_out, .phase3_neg_out,
    .irq
  );

  // Clock generator
  always #5 aclk = ~aclk;

  // Cycle count and hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count = err_count + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, got);
    end
  endtask : check

  // Compare bench-measured cycle counts
  task automatic cnt_chk(input string n, input int got, input int exp);
    check(n, 32'(got), 32'(exp));
  endtask : cnt_chk

  // Bus write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        aw_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        w_ok = 1'b1;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  // Bus read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  // Short register helpers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_write(a, {16'h0000, d}, r);
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(n, d, e);
  endtask : rd_chk

  // Pin waits and width measurement in cycles
  task automatic wait_pin(input int i, input logic v);
    while (pins[i] !== v)
      @(posedge aclk);
  endtask : wait_pin

  task automatic measure(input int i, input logic v, output int w);
    w = 0;
    wait_pin(i, !v);
    wait_pin(i, v);
    while (pins[i] === v)
    begin
      @(posedge aclk);
      w++;
    end
  endtask : measure

  // Cycles between two interrupt rises, status cleared before each
  task automatic irq_gap(input logic [15:0] m, output int dt);
    int t0;
    wr(OFS_IRQ_CLR, m);
    wait_pin(7, 1'b0);
    wait_pin(7, 1'b1);
    t0 = cyc;
    wr(OFS_IRQ_CLR, m);
    wait_pin(7, 1'b0);
    wait_pin(7, 1'b1);
    dt = cyc - t0;
  endtask : irq_gap

  // Counts and verdict
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int w;
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset state and refused accesses
    check("idle pins", {24'h0, pins}, 32'h0000_002A);
    rd_chk("period reset", OFS_PER_CMP, 32'h0000_09C3);
    rd_chk("count reset", OFS_COUNT, 32'h0000_0000);
    axi_read(8'h48, d, r);
    check("unmapped rd resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped rd data", d, 32'h0000_0000);
    axi_write(8'h4C, 32'h0000_0001, r);
    check("unmapped wr resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // Short period, duties 0, 2 and equal to period
    wr(OFS_PER_CMP, 16'h0009);
    wr(OFS_PER_BUF, 16'h0009);
    wr(OFS_D1_CMP, 16'h0000);
    wr(OFS_D2_CMP, 16'h0002);
    wr(OFS_D2_BUF, 16'h0002);
    wr(OFS_D3_CMP, 16'h0009);
    wr(OFS_D3_BUF, 16'h0009);
    wr(OFS_CTRL, 16'h0001);
    measure(0, 1'b1, w);
    cnt_chk("carrier", w, (PER + 1) * TICK);
    measure(1, 1'b1, w);
    cnt_chk("zero duty pulse", w, TICK);
    measure(3, 1'b0, w);
    cnt_chk("duty active", w, (PER - 2) * TICK);
    measure(3, 1'b1, w);
    cnt_chk("duty idle", w, 3 * TICK);
    measure(5, 1'b0, w);
    cnt_chk("full duty low", w, (PER + 1) * TICK);
    measure(5, 1'b1, w);
    cnt_chk("full duty high", w, (PER + 1) * TICK);
    // Negative pins complement positive ones
    for (int i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      check("complement", {29'h0, pins[2], pins[4], pins[6]},
            {29'h0, ~pins[1], ~pins[3], ~pins[5]});
    end
    // Period interrupt spacing, then masking
    wr(OFS_IRQ_EN, 16'h0001);
    irq_gap(16'h0001, w);
    cnt_chk("period irq gap", w, (PER + 1) * TICK);
    wr(OFS_IRQ_EN, 16'h0000);
    repeat (200) @(posedge aclk);
    check("masked irq", {31'h0, pins[7]}, 32'h0000_0000);
    rd_chk("period status", OFS_IRQ_STAT, 32'h0000_0001);
    // Buffered update lands only at the period match
    wr(OFS_MODE, 16'h0003);
    wait_pin(0, !pins[0]);
    wr(OFS_D2_BUF, 16'h0005);
    wr(OFS_PER_BUF, 16'h000B);
    rd_chk("duty held", OFS_D2_CMP, 32'h0000_0002);
    wait_pin(0, !pins[0]);
    repeat (4) @(posedge aclk);
    rd_chk("duty copied", OFS_D2_CMP, 32'h0000_0005);
    rd_chk("period copied", OFS_PER_CMP, 32'h0000_000B);
    measure(0, 1'b1, w);
    cnt_chk("new carrier", w, 12 * TICK);
    // Port levels: pos 1,0,1 then 1,1,0 per phase
    wr(OFS_PORT, 16'h002F);
    repeat (3) @(posedge aclk);
    check("port pins a", {26'h0, pins[6:1]}, 32'h0000_0019);
    wr(OFS_PORT, 16'h001F);
    repeat (3) @(posedge aclk);
    check("port pins b", {26'h0, pins[6:1]}, 32'h0000_0025);
    wr(OFS_PORT, 16'h0000);
    // Second channel: A clears its count, B marks the switch point
    wr(OFS_AUX_PER, 16'h0014);
    wr(OFS_AUX_SW, 16'h0007);
    wr(OFS_CTRL, 16'h0003);
    wr(OFS_IRQ_EN, 16'h0002);
    irq_gap(16'h0002, w);
    cnt_chk("aux a gap", w, 21 * TICK);
    wr(OFS_IRQ_EN, 16'h0004);
    irq_gap(16'h0004, w);
    cnt_chk("aux b gap", w, 21 * TICK);
    wr(OFS_CTRL, 16'h0001);
    summarize();
  end
endmodule : three_phase_reset_sync_pwm_tb

// *** rtl/rspwm_pkg.sv ***
// Constants, offsets and field layout of the three-phase PWM block
package rspwm_pkg;
  // Counter and compare width
  localparam int CNT_W = 16;
  // Clock rate and counter prescale
  localparam int CLK_HZ = 100_000_000;
  localparam int CNT_HZ = 6_250_000;
  localparam int PRESCALE = CLK_HZ / CNT_HZ;
  localparam logic [3:0] PRESCALE_MAX = 4'(PRESCALE - 1);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_PER_BUF = 8'h08;
  localparam logic [7:0] OFS_D1_BUF = 8'h0C;
  localparam logic [7:0] OFS_D2_BUF = 8'h10;
  localparam logic [7:0] OFS_D3_BUF = 8'h14;
  localparam logic [7:0] OFS_PER_CMP = 8'h18;
  localparam logic [7:0] OFS_D1_CMP = 8'h1C;
  localparam logic [7:0] OFS_D2_CMP = 8'h20;
  localparam logic [7:0] OFS_D3_CMP = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h28;
  localparam logic [7:0] OFS_AUX_PER = 8'h2C;
  localparam logic [7:0] OFS_AUX_SW = 8'h30;
  localparam logic [7:0] OFS_AUX_CNT = 8'h34;
  localparam logic [7:0] OFS_PORT = 8'h38;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h40;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h44;
  // Control bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUX_RUN = 1;
  // Mode bits: buffer enables
  localparam int MODE_BUF_A = 0;
  localparam int MODE_BUF_B = 1;
  // Port register: bits 2:0 select port per phase, 5:3 port level
  localparam int PORT_SEL_LSB = 0;
  localparam int PORT_LVL_LSB = 3;
  // Interrupt status bits
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_AUX_A = 1;
  localparam int IRQ_AUX_B = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h09C3;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  // Idle output level of an active-low output
  localparam logic OUT_IDLE = 1'b1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rspwm_pkg

// *** rtl/three_phase_reset_sync_pwm.sv ***
// Three-phase reset-synchronized PWM with AXI4-Lite registers
// Contract
// RULE_01 - Counter clears at period match, span N+1
// RULE_02 - Buffer enables make shadow registers active
// RULE_03 - Buffers copy to compares at period match
// RULE_04 - Zero duty gives one-count pulse
// RULE_05 - Duty at/above period toggles once per period
// RULE_06 - Software uses port mode for 0/100%
// RULE_07 - Port mode drives low 0%, high 100%
// RULE_08 - Period interrupt once per carrier period
// RULE_09 - Counter counts at clock divided by 16
// RULE_10 - Software sets period 400 us
// RULE_11 - All six PWM outputs active-low (code: the three positive outputs only; negatives reset low and drive wave_reg)
// RULE_12 - Three pairs plus period toggle output
// RULE_13 - Aux counter clears at its A match
// RULE_14 - Aux A interrupt marks 100% switchover
// RULE_15 - Aux B interrupt marks 0% switchover
// RULE_16 - Software writes duty into buffers only
// RULE_17 - Software starts/stops aux counter around interrupts
// RULE_18 - Outputs toggle at duty match and clear
// RULE_19 - Negative output complements positive under timer
`timescale 1ns/100ps
module three_phase_reset_sync_pwm
  import rspwm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PWM pins
  output logic period_toggle_out,
  output logic phase1_pos_out,
  output logic phase1_neg_out,
  output logic phase2_pos_out,
  output logic phase2_neg_out,
  output logic phase3_pos_out,
  output logic phase3_neg_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [3:0] pre_reg;
  logic tick_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] mode_reg;
  logic [CNT_W-1:0] period_buffer_reg;
  logic [CNT_W-1:0] period_compare_reg;
  logic [CNT_W-1:0] duty_buffer_reg [3];
  logic [CNT_W-1:0] duty_compare_reg [3];
  logic [CNT_W-1:0] period_counter_reg;
  logic [CNT_W-1:0] aux_period_compare_reg;
  logic [CNT_W-1:0] aux_switch_compare_reg;
  logic [CNT_W-1:0] aux_counter_reg;
  logic [5:0] port_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [2:0] wave_reg;
  logic [2:0] pos_reg;
  logic [2:0] neg_reg;
  logic toggle_reg;
  logic [1:0] aw_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: one-cycle enable per counter clock
  logic tick_d;
  assign tick_d = (pre_reg == PRESCALE_MAX);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_reg <= 4'h0;
    else
      pre_reg <= tick_d ? 4'h0 : pre_reg + 4'h1; // [RULE_09]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_reg <= 1'b0;
    else
      tick_reg <= tick_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period, aux A and aux B match decode
  wire run = ctrl_reg[CTRL_RUN];
  wire aux_run = ctrl_reg[CTRL_AUX_RUN];
  wire per_match = run && tick_reg &&
                   (period_counter_reg == period_compare_reg);
  wire aux_a_match = aux_run && tick_reg &&
                     (aux_counter_reg == aux_period_compare_reg);
  wire aux_b_match = aux_run && tick_reg &&
                     (aux_counter_reg == aux_switch_compare_reg);

  // Main counter clears on last count equal to period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      period_counter_reg <= CNT_RST;
    else if (per_match)
      period_counter_reg <= CNT_RST; // [RULE_01]
    else if (run && tick_reg)
      period_counter_reg <= period_counter_reg + 16'h0001;
  end

  // Aux normal-mode counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aux_counter_reg <= CNT_RST;
    else if (aux_a_match)
      aux_counter_reg <= CNT_RST; // [RULE_13]
    else if (aux_run && tick_reg)
      aux_counter_reg <= aux_counter_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write decode
  logic [1:0] aw_held_next;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [7:0] wa = aw_take ? s_axi_awaddr : awaddr_reg;
  wire [31:0] wd = w_take ? s_axi_wdata : wdata_reg;
  wire [3:0] ws = w_take ? s_axi_wstrb : wstrb_reg;
  wire a_ok = aw_take || aw_held_reg[0];
  wire d_ok = w_take || aw_held_reg[1];
  wire wr_go = a_ok && d_ok && !s_axi_bvalid;
  assign aw_held_next = wr_go ? 2'b00 : {d_ok, a_ok};

  // Byte-merged 16-bit write value
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  wire wr_ctrl = wr_go && ws[0] && (wa == OFS_CTRL);
  wire wr_mode = wr_go && ws[0] && (wa == OFS_MODE);
  wire wr_pbuf = wr_go && (wa == OFS_PER_BUF);
  wire wr_pcmp = wr_go && (wa == OFS_PER_CMP);
  wire wr_aper = wr_go && (wa == OFS_AUX_PER);
  wire wr_asw = wr_go && (wa == OFS_AUX_SW);
  wire wr_port = wr_go && ws[0] && (wa == OFS_PORT);
  wire wr_en = wr_go && ws[0] && (wa == OFS_IRQ_EN);
  wire wr_clr = wr_go && ws[0] && (wa == OFS_IRQ_CLR);
  wire wr_cnt = wr_go && (wa == OFS_COUNT);
  wire map_hit = (wa == OFS_CTRL) || (wa == OFS_MODE) ||
                 ((wa >= OFS_PER_BUF) && (wa <= OFS_IRQ_CLR) &&
                  (wa[1:0] == 2'b00));
  wire buf_on = mode_reg[MODE_BUF_A] && mode_reg[MODE_BUF_B];

  // Handshake and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      if (aw_take)
        awaddr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held_next[0] && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !aw_held_next[1] && !w_take && !s_axi_bvalid;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= map_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mode, aux and port registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= 2'b00;
      mode_reg <= 2'b00;
      port_reg <= 6'h00;
      irq_en_reg <= 3'b000;
      aux_period_compare_reg <= PERIOD_RST;
      aux_switch_compare_reg <= CNT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= wd[1:0];
      if (wr_mode)
        mode_reg <= wd[1:0];
      if (wr_port)
        port_reg <= wd[5:0];
      if (wr_en)
        irq_en_reg <= wd[IRQ_W-1:0];
      if (wr_aper)
        aux_period_compare_reg <= merge16(aux_period_compare_reg, wd, ws);
      if (wr_asw)
        aux_switch_compare_reg <= merge16(aux_switch_compare_reg, wd, ws);
    end
  end

  // Period buffer and compare; buffer copy at period match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_buffer_reg <= PERIOD_RST;
      period_compare_reg <= PERIOD_RST;
    end
    else
    begin
      if (wr_pbuf)
        period_buffer_reg <= merge16(period_buffer_reg, wd, ws);
      if (per_match && buf_on)
        period_compare_reg <= period_buffer_reg; // [RULE_02] [RULE_03]
      else if (wr_pcmp)
        period_compare_reg <= merge16(period_compare_reg, wd, ws);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase duty registers and waveform
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_phase
      wire [7:0] bofs = OFS_D1_BUF + 8'(4 * g);
      wire [7:0] cofs = OFS_D1_CMP + 8'(4 * g);
      wire duty_match = run && tick_reg &&
                        (period_counter_reg == duty_compare_reg[g]);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          duty_buffer_reg[g] <= CNT_RST;
          duty_compare_reg[g] <= CNT_RST;
        end
        else
        begin
          if (wr_go && wa == bofs)
            duty_buffer_reg[g] <= merge16(duty_buffer_reg[g], wd, ws);
          if (per_match && buf_on)
            duty_compare_reg[g] <= duty_buffer_reg[g]; // [RULE_03]
          else if (wr_go && wa == cofs)
            duty_compare_reg[g] <= merge16(duty_compare_reg[g], wd, ws);
        end
      end
      // Toggle on duty match or on clear; both at once give one toggle,
      // so a duty equal to the period still flips once per period
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          wave_reg[g] <= 1'b0;
        else
          wave_reg[g] <= wave_reg[g] ^ (duty_match || per_match); // [RULE_18]
      end
      // Pin drive: timer wave active-low, or port level
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          // Pair stays complementary through reset too
          pos_reg[g] <= OUT_IDLE;
          neg_reg[g] <= !OUT_IDLE; // [RULE_19]
        end
        else if (port_reg[PORT_SEL_LSB + g])
        begin
          pos_reg[g] <= port_reg[PORT_LVL_LSB + g]; // [RULE_07]
          neg_reg[g] <= !port_reg[PORT_LVL_LSB + g];
        end
        else
        begin
          pos_reg[g] <= !wave_reg[g]; // [RULE_11] [RULE_04] [RULE_05]
          neg_reg[g] <= wave_reg[g]; // [RULE_19]
        end
      end
    end
  endgenerate

  // Period-synchronized toggle output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      toggle_reg <= 1'b0;
    else if (per_match)
      toggle_reg <= !toggle_reg; // [RULE_12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over clear
  wire [IRQ_W-1:0] irq_set = {aux_b_match, aux_a_match, per_match};
  wire [IRQ_W-1:0] irq_clr = wr_clr ? wd[IRQ_W-1:0] : 3'b000;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_reg <= 3'b000;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | // [RULE_14] [RULE_15]
                      irq_set; // [RULE_08]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_en_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] rd_val;
  wire [7:0] ra = s_axi_araddr;
  wire rd_hit = (ra <= OFS_IRQ_CLR) && (ra[1:0] == 2'b00);
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (ra == OFS_CTRL) rd_val = {30'h0, ctrl_reg};
    else if (ra == OFS_MODE) rd_val = {30'h0, mode_reg};
    else if (ra == OFS_PER_BUF) rd_val = {16'h0, period_buffer_reg};
    else if (ra == OFS_D1_BUF) rd_val = {16'h0, duty_buffer_reg[0]};
    else if (ra == OFS_D2_BUF) rd_val = {16'h0, duty_buffer_reg[1]};
    else if (ra == OFS_D3_BUF) rd_val = {16'h0, duty_buffer_reg[2]};
    else if (ra == OFS_PER_CMP) rd_val = {16'h0, period_compare_reg};
    else if (ra == OFS_D1_CMP) rd_val = {16'h0, duty_compare_reg[0]};
    else if (ra == OFS_D2_CMP) rd_val = {16'h0, duty_compare_reg[1]};
    else if (ra == OFS_D3_CMP) rd_val = {16'h0, duty_compare_reg[2]};
    else if (ra == OFS_COUNT) rd_val = {16'h0, period_counter_reg};
    else if (ra == OFS_AUX_PER) rd_val = {16'h0, aux_period_compare_reg};
    else if (ra == OFS_AUX_SW) rd_val = {16'h0, aux_switch_compare_reg};
    else if (ra == OFS_AUX_CNT) rd_val = {16'h0, aux_counter_reg};
    else if (ra == OFS_PORT) rd_val = {26'h0, port_reg};
    else if (ra == OFS_IRQ_STAT) rd_val = {29'h0, irq_stat_reg};
    else if (ra == OFS_IRQ_EN) rd_val = {29'h0, irq_en_reg};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    end
  end

  // Pins from flops
  assign period_toggle_out = toggle_reg;
  assign phase1_pos_out = pos_reg[0];
  assign phase1_neg_out = neg_reg[0];
  assign phase2_pos_out = pos_reg[1];
  assign phase2_neg_out = neg_reg[1];
  assign phase3_pos_out = pos_reg[2];
  assign phase3_neg_out = neg_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    per_match |=> period_counter_reg == CNT_RST;
  endproperty
  a_clear: assert property (p_clear) // [RULE_01]
    else $error("counter not cleared");

  property p_bufcopy;
    @(posedge aclk) disable iff (!aresetn)
    (per_match && buf_on) |=> period_compare_reg == $past(period_buffer_reg);
  endproperty
  a_bufcopy: assert property (p_bufcopy) // [RULE_03]
    else $error("no buffer copy");

  property p_tick;
    @(posedge aclk) disable iff (!aresetn)
    tick_reg |=> !tick_reg ##1 !tick_reg ##1 !tick_reg;
  endproperty
  a_tick: assert property (p_tick) // [RULE_09]
    else $error("bad prescale");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    per_match |=> irq_stat_reg[IRQ_PERIOD];
  endproperty
  a_irq: assert property (p_irq) // [RULE_08]
    else $error("period irq missing");

  property p_comp;
    @(posedge aclk) disable iff (!aresetn)
    !port_reg[0] && !$past(port_reg[0]) |-> phase1_neg_out != phase1_pos_out;
  endproperty
  a_comp: assert property (p_comp) // [RULE_19]
    else $error("pair not complement");

  property p_port;
    @(posedge aclk) disable iff (!aresetn)
    port_reg[0] |=> phase1_pos_out == $past(port_reg[PORT_LVL_LSB]);
  endproperty
  a_port: assert property (p_port) // [RULE_07]
    else $error("port level wrong");

  property p_toggle;
    @(posedge aclk) disable iff (!aresetn)
    per_match |=> period_toggle_out != $past(period_toggle_out);
  endproperty
  a_toggle: assert property (p_toggle) // [RULE_12]
    else $error("no period toggle");

  property p_aux;
    @(posedge aclk) disable iff (!aresetn)
    aux_a_match |=> aux_counter_reg == CNT_RST && irq_stat_reg[IRQ_AUX_A];
  endproperty
  a_aux: assert property (p_aux) // [RULE_13] [RULE_14]
    else $error("aux clear wrong");

  property p_auxb;
    @(posedge aclk) disable iff (!aresetn)
    aux_b_match |=> irq_stat_reg[IRQ_AUX_B];
  endproperty
  a_auxb: assert property (p_auxb) // [RULE_15]
    else $error("aux b irq missing");

  property p_wave;
    @(posedge aclk) disable iff (!aresetn)
    (g_phase[0].duty_match || per_match) |=>
    wave_reg[0] != $past(wave_reg[0]);
  endproperty
  a_wave: assert property (p_wave) // [RULE_18] [RULE_05]
    else $error("wave no toggle");

  c_period: cover property (@(posedge aclk) per_match);
  c_aux: cover property (@(posedge aclk) aux_a_match);
  c_irq: cover property (@(posedge aclk) irq);
endmodule : three_phase_reset_sync_pwm
